//--- src/cosc_ctrl.sv
// control logic for two comparators and the second amplifier switch matrix
// assumes apb master on pclk; comparator outputs arrive asynchronously
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: bit 7 of trim control reads the comparator result; writes ignored.
// R2: bit 6 of trim control selects normal or offset trim mode.
// R3: comparator 1 trim forces shared and inverting source selects to pins, reading 1.
// R4: comparator 1 trim reference: 0 inverting pin, 1 shared pin.
// R5: comparator 2 trim reference: 0 own pin, 1 shared pin.
// R6: bits 4..0 hold the trim code, writable, reset 10000.
// R7: shared source select bit 7: 0 amplifier, 1 shared pin; reset 1.
// R8: comparator 1 inverting source bit 1: 0 high tap, 1 pin; reset 1.
// R9: comparator 2 positive source bit 1: 0 low tap, 1 pin; reset 1.
// R10: bit 0 powers comparator; when off its pins stay general I/O.
// R11: bit 2 drives comparator output onto its pin.
// R12: bit 3 allows comparator edges to request interrupts.
// R13: edge select 00 none, 01 rise, 10 fall, 11 both.
// R14: unimplemented path control bits ignore writes and read zero.
// R15: amplifier decode closes follower, gain, crossover and at most one reference tap switch (none for reference select 00).
// R16: amplifier off releases all three amplifier pins to general I/O.
// R17: amplifier on: output pin always, inputs only when pin select set.
// R18: on, gain and negative pin select bypass the input resistor.
// R19: leaving trim mode restores the forced source selects.
// R20: shared pin selected forces both amplifier-to-comparator routes off.
// R21: amplifier off clears gain enable and follower.
// R22: results synchronised; enabled selected edge gives one-cycle request.
// R23: disabled comparator reads result 0 and raises no requests.
module cosc_ctrl
  import cosc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  cmp_raw,
  output var  logic [1:0]  cmp_on,
  output var  logic [1:0]  cmp_trim_mode,
  output var  logic [1:0]  cmp_trim_ref_sel,
  output var  logic [4:0]  cmp1_trim_code,
  output var  logic [4:0]  cmp2_trim_code,
  output var  logic        shared_pos_src_sel,
  output var  logic        cmp1_neg_src_sel,
  output var  logic        cmp2_pos_src_sel,
  output var  logic        opa1_to_cmp,
  output var  logic        opa2_to_cmp,
  output var  logic [1:0]  cmp_pin_out,
  output var  logic [1:0]  cmp_pin_oe,
  output var  logic [1:0]  cmp_irq,
  output var  logic        opa2_follower_sw,
  output var  logic        opa2_gain_sw,
  output var  logic        opa2_r_bypass_sw,
  output var  logic        opa1_to_opa2_pos_sw,
  output var  logic        opa1_to_opa2_neg_sw,
  output var  logic [2:0]  opa2_ref_tap_sw,
  output var  logic        opa2_pos_port_pin,
  output var  logic        opa2_neg_port_pin,
  output var  logic        opa2_out_port_pin
);
  import cosc_pkg::*;

  // edge match shared by both comparators
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    case (sel)
      COSC_EDGE_RISE: edge_hit = rise;
      COSC_EDGE_FALL: edge_hit = fall;
      COSC_EDGE_BOTH: edge_hit = rise | fall;
      default:        edge_hit = 1'b0;
    endcase
  endfunction

  logic [1:0]  trim_mode_r;
  logic [1:0]  trim_ref_r;
  logic [4:0]  code1_r;
  logic [4:0]  code2_r;
  logic        shared_sw_r;
  logic        c1_neg_sw_r;
  logic        c2_pos_sw_r;
  logic [1:0]  on_r;
  logic [1:0]  irq_en_r;
  logic [1:0]  pout_r;
  logic [1:0]  edge_r;
  logic        opa_on_r;
  logic        opa_neg_pin_r;
  logic        opa_pos_pin_r;
  logic [1:0]  opa_ref_r;
  logic        opa_follow_r;
  logic        opa_gain_r;
  logic        opa_x_pos_r;
  logic        opa_x_neg_r;
  logic        opa1_cmp_r;
  logic        opa2_cmp_r;
  logic [1:0]  sync1_r;
  logic [1:0]  sync2_r;
  logic [1:0]  prev_r;
  logic        shared_eff;
  logic        c1_neg_eff;
  logic        c2_pos_eff;
  logic        o1cmp_eff;
  logic        o2cmp_eff;
  logic [1:0]  result;
  logic        wr_en;
  logic        setup;
  logic        addr_ok;
  logic [31:0] rd_nxt;

  // zero wait states; a frozen clock enable stretches the access phase
  assign pready  = pclk_en;
  assign setup   = psel & ~penable & pclk_en;
  assign wr_en   = psel & penable & pwrite & pclk_en;
  assign addr_ok = (paddr == CMP1_TRIM_OFS) || (paddr == CMP1_PATH_OFS) || (paddr == CMP2_TRIM_OFS)
                || (paddr == CMP2_PATH_OFS) || (paddr == OPA2_CTRL_OFS);
  assign pslverr = psel & penable & ~addr_ok;

  // forced views; the stored copies keep the software value for restore
  assign shared_eff = shared_sw_r | trim_mode_r[0] | trim_mode_r[1]; // R3
  assign c1_neg_eff = c1_neg_sw_r | trim_mode_r[0]; // R3
  assign c2_pos_eff = c2_pos_sw_r | trim_mode_r[1];
  assign o1cmp_eff  = opa1_cmp_r & ~shared_eff; // R20
  assign o2cmp_eff  = opa2_cmp_r & ~shared_eff & ~o1cmp_eff; // R20
  assign result     = sync2_r & on_r; // R23

  // comparator trim registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_mode_r <= 2'h0;
      trim_ref_r  <= 2'h0;
      code1_r     <= TRIM_CODE_RST; // R6
      code2_r     <= TRIM_CODE_RST;
    end else if (wr_en && paddr == CMP1_TRIM_OFS) begin
      trim_mode_r[0] <= pwdata[TRIM_MODE_BIT]; // R2
      trim_ref_r[0]  <= pwdata[TRIM_REF_BIT]; // R4
      code1_r        <= pwdata[TRIM_CODE_HI:0]; // R6
    end else if (wr_en && paddr == CMP2_TRIM_OFS) begin
      trim_mode_r[1] <= pwdata[TRIM_MODE_BIT]; // R2
      trim_ref_r[1]  <= pwdata[TRIM_REF_BIT]; // R5
      code2_r        <= pwdata[TRIM_CODE_HI:0];
    end
  end

  // comparator path registers; forced bits keep their stored value during trim
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_sw_r <= SHARED_SRC_RST; // R7
      c1_neg_sw_r <= SRC_SEL_RST; // R8
      c2_pos_sw_r <= SRC_SEL_RST; // R9
      on_r        <= 2'h0;
      irq_en_r    <= 2'h0;
      pout_r      <= 2'h0;
      edge_r      <= EDGE_SEL_RST;
    end else if (wr_en && paddr == CMP1_PATH_OFS) begin
      if (!(trim_mode_r[0] || trim_mode_r[1])) begin
        shared_sw_r <= pwdata[SHARED_SRC_BIT]; // R19
      end
      if (!trim_mode_r[0]) begin
        c1_neg_sw_r <= pwdata[SRC_SEL_BIT]; // R19
      end
      irq_en_r[0] <= pwdata[IRQ_EN_BIT]; // R12
      pout_r[0]   <= pwdata[PIN_OUT_BIT]; // R11
      on_r[0]     <= pwdata[CMP_ON_BIT]; // R10
    end else if (wr_en && paddr == CMP2_PATH_OFS) begin
      edge_r      <= pwdata[EDGE_SEL_HI:EDGE_SEL_LO]; // R13
      if (!trim_mode_r[1]) begin
        c2_pos_sw_r <= pwdata[SRC_SEL_BIT];
      end
      irq_en_r[1] <= pwdata[IRQ_EN_BIT]; // R12
      pout_r[1]   <= pwdata[PIN_OUT_BIT]; // R11
      on_r[1]     <= pwdata[CMP_ON_BIT]; // R10
    end
  end

  // amplifier control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa_on_r      <= 1'b0;
      opa_neg_pin_r <= OPA_PIN_SEL_RST;
      opa_pos_pin_r <= OPA_PIN_SEL_RST;
      opa_ref_r     <= 2'h0;
      opa_follow_r  <= 1'b0;
      opa_gain_r    <= 1'b0;
      opa_x_pos_r   <= 1'b0;
      opa_x_neg_r   <= 1'b0;
      opa1_cmp_r    <= 1'b0;
      opa2_cmp_r    <= 1'b0;
    end else if (wr_en && paddr == OPA2_CTRL_OFS) begin
      opa_on_r      <= pwdata[OPA_ON_BIT];
      opa_neg_pin_r <= pwdata[OPA_NEG_PIN_BIT];
      opa_pos_pin_r <= pwdata[OPA_POS_PIN_BIT];
      opa_ref_r     <= pwdata[OPA_REF_HI:OPA_REF_LO];
      // follower and gain cannot be held while the amplifier is off
      opa_follow_r  <= pwdata[OPA_FOLLOW_BIT] & pwdata[OPA_ON_BIT]; // R21
      opa_gain_r    <= pwdata[OPA_GAIN_BIT] & pwdata[OPA_ON_BIT]; // R21
      opa_x_pos_r   <= pwdata[OPA_X_POS_BIT];
      opa_x_neg_r   <= pwdata[OPA_X_NEG_BIT];
      opa1_cmp_r    <= pwdata[OPA1_CMP_BIT];
      opa2_cmp_r    <= pwdata[OPA2_CMP_BIT];
    end
  end

  // readback mux; unused bit positions read zero
  always_comb begin
    rd_nxt = RDATA_RST;
    case (paddr)
      CMP1_TRIM_OFS: begin
        rd_nxt[RESULT_BIT]        = result[0]; // R1
        rd_nxt[TRIM_MODE_BIT]     = trim_mode_r[0];
        rd_nxt[TRIM_REF_BIT]      = trim_ref_r[0];
        rd_nxt[TRIM_CODE_HI:0]    = code1_r;
      end
      CMP2_TRIM_OFS: begin
        rd_nxt[RESULT_BIT]        = result[1]; // R1
        rd_nxt[TRIM_MODE_BIT]     = trim_mode_r[1];
        rd_nxt[TRIM_REF_BIT]      = trim_ref_r[1];
        rd_nxt[TRIM_CODE_HI:0]    = code2_r;
      end
      CMP1_PATH_OFS: begin
        rd_nxt[SHARED_SRC_BIT]    = shared_eff; // R3
        rd_nxt[IRQ_EN_BIT]        = irq_en_r[0];
        rd_nxt[PIN_OUT_BIT]       = pout_r[0];
        rd_nxt[SRC_SEL_BIT]       = c1_neg_eff; // R3
        rd_nxt[CMP_ON_BIT]        = on_r[0];
      end
      CMP2_PATH_OFS: begin
        rd_nxt[EDGE_SEL_HI:EDGE_SEL_LO] = edge_r;
        rd_nxt[IRQ_EN_BIT]        = irq_en_r[1];
        rd_nxt[PIN_OUT_BIT]       = pout_r[1];
        rd_nxt[SRC_SEL_BIT]       = c2_pos_eff;
        rd_nxt[CMP_ON_BIT]        = on_r[1];
      end
      OPA2_CTRL_OFS: begin
        rd_nxt[OPA_ON_BIT]        = opa_on_r;
        rd_nxt[OPA_NEG_PIN_BIT]   = opa_neg_pin_r;
        rd_nxt[OPA_POS_PIN_BIT]   = opa_pos_pin_r;
        rd_nxt[OPA_REF_HI:OPA_REF_LO] = opa_ref_r;
        rd_nxt[OPA_FOLLOW_BIT]    = opa_follow_r;
        rd_nxt[OPA_GAIN_BIT]      = opa_gain_r;
        rd_nxt[OPA_X_POS_BIT]     = opa_x_pos_r;
        rd_nxt[OPA_X_NEG_BIT]     = opa_x_neg_r;
        rd_nxt[OPA1_CMP_BIT]      = o1cmp_eff; // R20
        rd_nxt[OPA2_CMP_BIT]      = o2cmp_eff; // R20
      end
      default: rd_nxt = RDATA_RST; // R14
    endcase
  end

  // read data is captured in the setup cycle and held through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RDATA_RST;
    end else if (setup && !pwrite) begin
      prdata <= rd_nxt;
    end
  end

  // synchronisers and edge detection, one per comparator
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cmp
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          prev_r[gi]  <= 1'b0;
          cmp_irq[gi] <= 1'b0;
        end else if (pclk_en) begin
          sync1_r[gi] <= cmp_raw[gi]; // R22
          sync2_r[gi] <= sync1_r[gi];
          prev_r[gi]  <= sync2_r[gi];
          // one shared edge field serves both comparators
          cmp_irq[gi] <= on_r[gi] & irq_en_r[gi] & edge_hit(edge_r, sync2_r[gi], prev_r[gi]); // R22
        end
      end
    end
  endgenerate

  // switch and pin decode, registered so every control output is glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_on              <= 2'h0;
      cmp_trim_mode       <= 2'h0;
      cmp_trim_ref_sel    <= 2'h0;
      cmp1_trim_code      <= TRIM_CODE_RST;
      cmp2_trim_code      <= TRIM_CODE_RST;
      shared_pos_src_sel  <= SHARED_SRC_RST;
      cmp1_neg_src_sel    <= SRC_SEL_RST;
      cmp2_pos_src_sel    <= SRC_SEL_RST;
      opa1_to_cmp         <= 1'b0;
      opa2_to_cmp         <= 1'b0;
      cmp_pin_out         <= 2'h0;
      cmp_pin_oe          <= 2'h0;
      opa2_follower_sw    <= 1'b0;
      opa2_gain_sw        <= 1'b0;
      opa2_r_bypass_sw    <= 1'b0;
      opa1_to_opa2_pos_sw <= 1'b0;
      opa1_to_opa2_neg_sw <= 1'b0;
      opa2_ref_tap_sw     <= 3'h0;
      opa2_pos_port_pin   <= 1'b0;
      opa2_neg_port_pin   <= 1'b0;
      opa2_out_port_pin   <= 1'b0;
    end else if (pclk_en) begin
      cmp_on              <= on_r; // R10
      cmp_trim_mode       <= trim_mode_r; // R2
      cmp_trim_ref_sel    <= trim_ref_r; // R4 R5
      cmp1_trim_code      <= code1_r;
      cmp2_trim_code      <= code2_r;
      shared_pos_src_sel  <= shared_eff; // R7
      cmp1_neg_src_sel    <= c1_neg_eff; // R8
      cmp2_pos_src_sel    <= c2_pos_eff; // R9
      opa1_to_cmp         <= o1cmp_eff;
      opa2_to_cmp         <= o2cmp_eff;
      cmp_pin_out         <= result;
      cmp_pin_oe          <= on_r & pout_r; // R11
      opa2_follower_sw    <= opa_on_r & opa_follow_r; // R15
      opa2_gain_sw        <= opa_on_r & opa_gain_r; // R15
      opa2_r_bypass_sw    <= opa_on_r & opa_gain_r & opa_neg_pin_r; // R18
      opa1_to_opa2_pos_sw <= opa_on_r & opa_x_pos_r; // R15
      opa1_to_opa2_neg_sw <= opa_on_r & opa_x_neg_r; // R15
      opa2_ref_tap_sw[0]  <= opa_on_r & (opa_ref_r == 2'h1); // R15
      opa2_ref_tap_sw[1]  <= opa_on_r & (opa_ref_r == 2'h2);
      opa2_ref_tap_sw[2]  <= opa_on_r & (opa_ref_r == 2'h3);
      opa2_pos_port_pin   <= opa_on_r & opa_pos_pin_r; // R17
      opa2_neg_port_pin   <= opa_on_r & opa_neg_pin_r; // R17
      opa2_out_port_pin   <= opa_on_r; // R16
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_trim_forces_src: assert property (trim_mode_r[0] |-> shared_eff && c1_neg_eff) // R3
    else $error("trim mode did not force source selects");
  a_trim_restore: assert property ($fell(trim_mode_r[0]) && !trim_mode_r[1] |-> // R19
    shared_eff == $past(shared_sw_r) && c1_neg_eff == $past(c1_neg_sw_r))
    else $error("source selects not restored after trim");
  a_shared_blocks_opa: assert property (shared_eff |-> !o1cmp_eff && !o2cmp_eff) // R20
    else $error("amplifier route open while shared pin selected");
  a_opa_off_clear: assert property (!opa_on_r |-> !opa_gain_r && !opa_follow_r) // R21
    else $error("gain or follower held while amplifier off");
  a_opa_off_release: assert property (pclk_en && !opa_on_r |=> // R16
    !opa2_out_port_pin && !opa2_pos_port_pin && !opa2_neg_port_pin && opa2_ref_tap_sw == 3'h0)
    else $error("amplifier pins not released while off");
  a_bypass_decode: assert property (pclk_en && opa_on_r && opa_gain_r && opa_neg_pin_r |=> opa2_r_bypass_sw) // R18
    else $error("input resistor not bypassed");
  a_irq_cause: assert property (cmp_irq[0] |-> $past(on_r[0] && irq_en_r[0] && edge_r != 2'h0)) // R12
    else $error("comparator 1 request without enable");
  a_irq_rise_only: assert property (pclk_en && edge_r == 2'h1 && on_r[1] && irq_en_r[1]
    && sync2_r[1] && !prev_r[1] |=> cmp_irq[1]) // R13
    else $error("rising edge did not raise request");
  a_pin_oe_gate: assert property (pclk_en && !(on_r[0] && pout_r[0]) |=> !cmp_pin_oe[0]) // R11
    else $error("comparator 1 pin driven while not enabled");
  a_result_off: assert property (!on_r[1] |-> !result[1]) // R23
    else $error("disabled comparator shows a result");
  a_trim2_forces_src: assert property (trim_mode_r[1] |-> shared_eff && c2_pos_eff) // R2
    else $error("comparator 2 trim did not force source selects");
  a_trim_code_out: assert property (pclk_en |=> cmp1_trim_code == $past(code1_r)) // R6
    else $error("trim code output does not follow register");
  a_pin2_oe_drive: assert property (pclk_en && on_r[1] && pout_r[1] |=> cmp_pin_oe[1]) // R11
    else $error("comparator 2 pin not driven while enabled");
  // two closed taps would short reference levels together
  a_tap_onehot: assert property ($onehot0(opa2_ref_tap_sw)) // R15
    else $error("more than one reference tap switch closed");
endmodule // cosc_ctrl
`default_nettype wire

//--- src/cosc_pkg.sv
// package for the comparator and amplifier switch control block
// assumes a 32-bit apb slave on pclk with word-aligned registers
package cosc_pkg;
  // register byte offsets
  localparam logic [11:0] CMP1_TRIM_OFS = 12'h000;
  localparam logic [11:0] CMP1_PATH_OFS = 12'h004;
  localparam logic [11:0] CMP2_TRIM_OFS = 12'h008;
  localparam logic [11:0] CMP2_PATH_OFS = 12'h00C;
  localparam logic [11:0] OPA2_CTRL_OFS = 12'h010;
  // trim control fields
  localparam int RESULT_BIT    = 7;
  localparam int TRIM_MODE_BIT = 6;
  localparam int TRIM_REF_BIT  = 5;
  localparam int TRIM_CODE_HI  = 4;
  localparam int TRIM_CODE_W   = 5;
  localparam logic [4:0] TRIM_CODE_RST = 5'h10;
  // path control fields
  localparam int SHARED_SRC_BIT = 7;
  localparam int EDGE_SEL_HI    = 7;
  localparam int EDGE_SEL_LO    = 6;
  localparam int IRQ_EN_BIT     = 3;
  localparam int PIN_OUT_BIT    = 2;
  localparam int SRC_SEL_BIT    = 1;
  localparam int CMP_ON_BIT     = 0;
  localparam logic SHARED_SRC_RST = 1'b1;
  localparam logic SRC_SEL_RST    = 1'b1;
  // amplifier control fields
  localparam int OPA_ON_BIT      = 0;
  localparam int OPA_NEG_PIN_BIT = 1;
  localparam int OPA_POS_PIN_BIT = 2;
  localparam int OPA_REF_LO      = 3;
  localparam int OPA_REF_HI      = 4;
  localparam int OPA_FOLLOW_BIT  = 5;
  localparam int OPA_GAIN_BIT    = 6;
  localparam int OPA_X_POS_BIT   = 7;
  localparam int OPA_X_NEG_BIT   = 8;
  localparam int OPA1_CMP_BIT    = 9;
  localparam int OPA2_CMP_BIT    = 10;
  localparam logic OPA_PIN_SEL_RST = 1'b1;
  // interrupt edge selection
  typedef enum logic [1:0] {
    COSC_EDGE_NONE = 2'h0,
    COSC_EDGE_RISE = 2'h1,
    COSC_EDGE_FALL = 2'h2,
    COSC_EDGE_BOTH = 2'h3
  } cosc_edge_e;
  localparam cosc_edge_e EDGE_SEL_RST = COSC_EDGE_NONE;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage

//--- testbench/comparator_opamp_switch_control_tb_top.sv
// self-checking testbench for the comparator and amplifier switch control block
// assumes cosc_pkg is compiled first; the bench drives apb and the comparator outputs itself
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t %s got %0h exp %0h", $time, m, g, e); end end
module comparator_opamp_switch_control_tb_top;
  import cosc_pkg::*;
  logic        pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, seed, r, d, ex;
  logic [1:0]  cmp_raw, cmp_on, cmp_trim_mode, cmp_trim_ref_sel, cmp_pin_out, cmp_pin_oe, cmp_irq;
  logic [4:0]  cmp1_trim_code, cmp2_trim_code;
  logic        shared_pos_src_sel, cmp1_neg_src_sel, cmp2_pos_src_sel, opa1_to_cmp, opa2_to_cmp;
  logic        opa2_follower_sw, opa2_gain_sw, opa2_r_bypass_sw, opa1_to_opa2_pos_sw, opa1_to_opa2_neg_sw;
  logic [2:0]  opa2_ref_tap_sw;
  logic        opa2_pos_port_pin, opa2_neg_port_pin, opa2_out_port_pin;
  int          n_fail, total_checks, n_irq0, n_irq1;
  logic [11:0] reg_adr [5] = '{CMP1_TRIM_OFS, CMP1_PATH_OFS, CMP2_TRIM_OFS, CMP2_PATH_OFS, OPA2_CTRL_OFS};
  logic [31:0] reg_rst [5] = '{32'h0000_0010, 32'h0000_0082, 32'h0000_0010, 32'h0000_0002, 32'h0000_0006};

  cosc_ctrl DUT (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_raw(cmp_raw), .cmp_on(cmp_on), .cmp_trim_mode(cmp_trim_mode),
    .cmp_trim_ref_sel(cmp_trim_ref_sel), .cmp1_trim_code(cmp1_trim_code), .cmp2_trim_code(cmp2_trim_code),
    .shared_pos_src_sel(shared_pos_src_sel), .cmp1_neg_src_sel(cmp1_neg_src_sel),
    .cmp2_pos_src_sel(cmp2_pos_src_sel), .opa1_to_cmp(opa1_to_cmp), .opa2_to_cmp(opa2_to_cmp),
    .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe), .cmp_irq(cmp_irq),
    .opa2_follower_sw(opa2_follower_sw), .opa2_gain_sw(opa2_gain_sw), .opa2_r_bypass_sw(opa2_r_bypass_sw),
    .opa1_to_opa2_pos_sw(opa1_to_opa2_pos_sw), .opa1_to_opa2_neg_sw(opa1_to_opa2_neg_sw),
    .opa2_ref_tap_sw(opa2_ref_tap_sw), .opa2_pos_port_pin(opa2_pos_port_pin),
    .opa2_neg_port_pin(opa2_neg_port_pin), .opa2_out_port_pin(opa2_out_port_pin)
  );

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  // pulses are counted rather than caught, so a stretched pulse shows up as an extra count
  always @(posedge pclk) begin
    if (cmp_irq[0] === 1'b1) n_irq0++;
    if (cmp_irq[1] === 1'b1) n_irq1++;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // amplifier register readback: follower and gain only stick while on, routes forced off by shared pin
  function automatic logic [31:0] amp_exp(input logic [31:0] v, input logic sh);
    amp_exp = v & 32'h0000_019F;
    if (v[0]) amp_exp[6:5] = v[6:5];
    amp_exp[9] = v[9] & ~sh;
    amp_exp[10] = v[10] & ~sh & ~amp_exp[9];
  endfunction

  function automatic logic [2:0] tap_exp(input logic [1:0] s);
    tap_exp = (s == 2'b00) ? 3'b000 : (3'b001 << (s - 2'b01));
  endfunction

  task automatic tally_and_finish();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; an idle edge first so no signal is assigned twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k == 64) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask

  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  // one rise and one fall on both comparators, with a clock-enable stall in between
  task automatic pulse_both();
    n_irq0 = 0; n_irq1 = 0;
    cmp_raw <= 2'b11;
    cyc(1);
    pclk_en <= 1'b0;
    cyc(3);
    pclk_en <= 1'b1;
    cyc(8);
    cmp_raw <= 2'b00;
    cyc(10);
  endtask

  initial begin
    presetn = 1'b0; pclk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; cmp_raw = 2'b00; seed = 32'h0001_20A5;
    n_fail = 0; total_checks = 0; n_irq0 = 0; n_irq1 = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(reg_adr[i]);
      `CHK(rdv, reg_rst[i], "reset value");
    end
    rd(12'h014);
    `CHK({rerr, rdv}, {1'b1, 32'h0000_0000}, "unmapped read");
    wr(CMP1_TRIM_OFS, 32'h0000_009F);
    rd(CMP1_TRIM_OFS);
    `CHK(rdv, 32'h0000_001F, "result bit written");
    `CHK(cmp1_trim_code, 5'h1F, "trim code out");
    wr(CMP2_PATH_OFS, 32'hFFFF_FFF2);
    rd(CMP2_PATH_OFS);
    `CHK(rdv, 32'h0000_00C2, "cmp2 path unused bits");
    wr(CMP1_PATH_OFS, 32'h0000_0071);
    rd(CMP1_PATH_OFS);
    `CHK(rdv, 32'h0000_0001, "cmp1 path unused bits");
    wr(OPA2_CTRL_OFS, 32'h0000_0600);
    cyc(2);
    `CHK({shared_pos_src_sel, cmp1_neg_src_sel, opa1_to_cmp, opa2_to_cmp}, 4'b0010, "amp routes");
    wr(CMP1_TRIM_OFS, 32'h0000_0070);
    cyc(2);
    `CHK({cmp_trim_mode[0], cmp_trim_ref_sel[0]}, 2'b11, "trim mode out");
    `CHK({shared_pos_src_sel, cmp1_neg_src_sel, opa1_to_cmp}, 3'b110, "trim forcing");
    rd(CMP1_PATH_OFS);
    `CHK(rdv, 32'h0000_0083, "forced readback");
    wr(CMP1_TRIM_OFS, 32'h0000_0010);
    cyc(2);
    `CHK({shared_pos_src_sel, cmp1_neg_src_sel, cmp_trim_mode[0]}, 3'b000, "trim exit");
    rd(CMP1_PATH_OFS);
    `CHK(rdv, 32'h0000_0001, "restored readback");
    wr(CMP2_TRIM_OFS, 32'h0000_0020);
    cyc(2);
    `CHK(cmp_trim_ref_sel[1], 1'b1, "cmp2 reference select");
    wr(CMP1_PATH_OFS, 32'h0000_008F);
    for (int s = 0; s < 4; s++) begin
      wr(CMP2_PATH_OFS, 32'h0000_000F | (32'(s) << 6));
      pulse_both();
      `CHK(n_irq0, s % 2 + s / 2, "cmp1 edge count");
      `CHK(n_irq1, s % 2 + s / 2, "cmp2 edge count");
    end
    cmp_raw <= 2'b01;
    cyc(6);
    rd(CMP1_TRIM_OFS);
    `CHK(rdv, 32'h0000_0090, "result high");
    `CHK({cmp_pin_oe, cmp_pin_out[0], cmp_on[0]}, 4'b1111, "pin drive");
    cmp_raw <= 2'b00;
    cyc(6);
    wr(CMP1_PATH_OFS, 32'h0000_0087);
    wr(CMP2_PATH_OFS, 32'h0000_00C2);
    pulse_both();
    `CHK({n_irq0, n_irq1}, 64'd0, "irq gated");
    cmp_raw <= 2'b11;
    cyc(6);
    rd(CMP2_TRIM_OFS);
    `CHK({rdv[7], cmp_on[1], cmp_pin_out[1]}, 3'b000, "disabled result");
    wr(CMP2_PATH_OFS, 32'h0000_0000);
    wr(CMP2_TRIM_OFS, 32'h0000_0040);
    wr(CMP2_PATH_OFS, 32'h0000_0002);
    cyc(2);
    `CHK({cmp_trim_mode[1], cmp2_pos_src_sel}, 2'b11, "cmp2 trim forcing");
    rd(CMP2_PATH_OFS);
    `CHK(rdv, 32'h0000_0002, "cmp2 forced readback");
    wr(CMP2_TRIM_OFS, 32'h0000_0000);
    cyc(2);
    `CHK({cmp_trim_mode[1], cmp2_pos_src_sel}, 2'b00, "cmp2 trim exit");
    rd(CMP2_PATH_OFS);
    `CHK(rdv, 32'h0000_0000, "cmp2 restored readback");
    wr(CMP1_PATH_OFS, 32'h0000_0080);
    for (int i = 0; i < 24; i++) begin
      r = xs();
      d = (i == 0) ? 32'h0000_007F : {21'h00_0000, r[10:0]};
      cmp_raw <= r[17:16];
      wr(CMP1_PATH_OFS, {24'h00_0000, r[18], 7'h00});
      wr(OPA2_CTRL_OFS, d);
      wr(CMP2_TRIM_OFS, {27'h000_0000, r[15:11]});
      cyc(2);
      rd(OPA2_CTRL_OFS);
      ex = amp_exp(d, r[18]);
      `CHK(rdv, ex, "amp readback");
      `CHK({opa2_to_cmp, opa1_to_cmp}, ex[10:9], "amp to comparator");
      `CHK(cmp2_trim_code, r[15:11], "cmp2 trim code");
      `CHK({opa2_follower_sw, opa2_gain_sw}, {d[0] & d[5], d[0] & d[6]}, "follower gain");
      `CHK(opa2_r_bypass_sw, d[0] & d[6] & d[1], "resistor bypass");
      `CHK({opa2_out_port_pin, opa2_neg_port_pin, opa2_pos_port_pin}, {d[0], d[0] & d[1], d[0] & d[2]}, "pins");
      if (d[0]) begin
        `CHK({opa1_to_opa2_neg_sw, opa1_to_opa2_pos_sw}, d[8:7], "crossover");
        `CHK(opa2_ref_tap_sw, tap_exp(d[4:3]), "reference tap");
      end else begin
        `CHK({opa1_to_opa2_neg_sw, opa1_to_opa2_pos_sw, opa2_ref_tap_sw}, 5'h00, "amp off switches");
      end
    end
    tally_and_finish();
  end
endmodule // comparator_opamp_switch_control_tb_top
`default_nettype wire
